/* core/pbc_ctrl_reg.sv */
// PHY basic control register at management address 0
// How it works
// - Writing one to bit 15 starts a full PHY reset immediately.
// - Bit 15 clears itself when the PHY reset completes.
// - Bit 14 is the master loopback enable, one on, zero off.
// - Loopback kind comes from the loopback control register, address 19.
// - Manual speed is bits 6 and 13: 00=10, 01=100, 10=1000, 11 reserved.
// - Manual speed acts only while auto-negotiation is disabled.
// - Bit 12 one runs auto-negotiation; zero uses the manual settings.
// - Bit 10 isolates the PHY from the MII or GMII.
// - Writing one to bit 9 restarts auto-negotiation, then clears itself.
// - Bit 8 chooses manual duplex, full when one, only without auto-negotiation.
// - Bit 7 enables the standard collision test.
// - Bits 5 to 0 read zero and ignore writes.
`timescale 1ns/1ps
module pbc_ctrl_reg
  import pbc_pkg::*;
#(
  parameter int RST_CYC = PHY_RST_CYCLES,
  parameter int ANR_CYC = AN_RESTART_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [MGMT_ADDR_W-1:0] mgmt_addr,
  input wire logic mgmt_wr,
  input wire logic mgmt_rd,
  input wire logic [MGMT_DATA_W-1:0] mgmt_wdata,
  output logic [MGMT_DATA_W-1:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire logic [LOOP_KIND_W-1:0] loop_kind_sel,
  input wire logic [1:0] an_speed,
  input wire logic an_full_duplex,
  output logic phy_rst_busy,
  output logic loopback_on,
  output logic [LOOP_KIND_W-1:0] loop_kind,
  output logic autoneg_on,
  output logic an_restart,
  output logic power_down,
  output logic isolate,
  output logic coll_test,
  output pbc_speed_t link_speed,
  output logic link_full_duplex
);

  pbc_state_t state;
  pbc_state_t next_state;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [MGMT_DATA_W-1:0] next_rdata;
  logic next_rvalid;
  logic wr_hit;
  logic rst_start;
  logic rst_done;
  logic anr_start;
  logic anr_done;

  // ----------------------------------------------------------------
  // Register write and self-clearing control
  // ----------------------------------------------------------------
  assign wr_hit = mgmt_wr && (mgmt_addr == CTRL_ADDR);
  assign rst_start = wr_hit && (state == ST_RUN) && mgmt_wdata[BIT_PHY_RST];
  assign anr_start = wr_hit && (state == ST_RUN) && !mgmt_wdata[BIT_PHY_RST]
                     && mgmt_wdata[BIT_AN_RESTART];

  always_comb begin
    next_state = state;
    next_ctrl = ctrl;
    unique case (state)
      ST_RUN: begin
        if (rst_start) begin
          // Reset returns every field but bit 15 to its default while it runs
          next_ctrl = CTRL_RESET_VAL;
          next_ctrl[BIT_PHY_RST] = 1'b1;
          next_state = ST_PHY_RST;
        end else begin
          if (wr_hit) begin
            next_ctrl = mgmt_wdata & ~CTRL_RSVD_MASK;
          end
          // A fresh request wins over the end of the previous one
          next_ctrl[BIT_AN_RESTART] = anr_start ||
              (ctrl[BIT_AN_RESTART] && !anr_done);
        end
      end
      ST_PHY_RST: begin
        // Writes are ignored until the PHY reset completes
        if (rst_done) begin
          next_ctrl[BIT_PHY_RST] = 1'b0;
          next_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_RUN;
      ctrl <= CTRL_RESET_VAL;
    end else begin
      state <= next_state;
      ctrl <= next_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Register read
  // ----------------------------------------------------------------
  always_comb begin
    next_rvalid = mgmt_rd && (mgmt_addr == CTRL_ADDR);
    next_rdata = next_rvalid ? (ctrl & ~CTRL_RSVD_MASK) : 16'h0000;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mgmt_rdata <= 16'h0000;
      mgmt_rvalid <= 1'b0;
    end else begin
      mgmt_rdata <= next_rdata;
      mgmt_rvalid <= next_rvalid;
    end
  end

  // ----------------------------------------------------------------
  // Timers and link settings
  // ----------------------------------------------------------------
  pbc_sc_timer #(.CYCLES(RST_CYC)) u_rst_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(rst_start),
    .busy(),
    .done(rst_done)
  );

  pbc_sc_timer #(.CYCLES(ANR_CYC)) u_anr_timer (
    .clock(clock),
    .sys_rst(sys_rst),
    .start(anr_start),
    .busy(),
    .done(anr_done)
  );

  pbc_link_cfg u_link_cfg (
    .clock(clock),
    .sys_rst(sys_rst),
    .autoneg_on(ctrl[BIT_AUTONEG_ON]),
    .man_speed({ctrl[BIT_SPD_MSB], ctrl[BIT_SPD_LSB]}),
    .man_full_duplex(ctrl[BIT_DUPLEX]),
    .an_speed(an_speed),
    .an_full_duplex(an_full_duplex),
    .loop_en(ctrl[BIT_LOOPBACK]),
    .loop_kind_sel(loop_kind_sel),
    .link_speed(link_speed),
    .link_full_duplex(link_full_duplex),
    .loop_kind(loop_kind)
  );

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign phy_rst_busy = ctrl[BIT_PHY_RST];
  assign loopback_on = ctrl[BIT_LOOPBACK];
  assign autoneg_on = ctrl[BIT_AUTONEG_ON];
  assign an_restart = ctrl[BIT_AN_RESTART];
  assign power_down = ctrl[BIT_PWR_DOWN];
  assign isolate = ctrl[BIT_ISOLATE];
  assign coll_test = ctrl[BIT_COLL_TEST];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [15:0] rst_hi_cnt;

  always_ff @(posedge clock) begin
    if (sys_rst || !ctrl[BIT_PHY_RST]) begin
      rst_hi_cnt <= 16'h0000;
    end else begin
      rst_hi_cnt <= rst_hi_cnt + 16'h0001;
    end
  end

  rst_start_a: assert property (@(posedge clock) disable iff (sys_rst)
    rst_start |=> phy_rst_busy && (state == ST_PHY_RST) && autoneg_on && !loopback_on)
    else $error("PHY reset did not start on write");

  rst_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    rst_hi_cnt <= 16'(RST_CYC))
    else $error("PHY reset bit not cleared in time");

  loop_kind_a: assert property (@(posedge clock) disable iff (sys_rst)
    ##1 loop_kind == ($past(loopback_on) ? $past(loop_kind_sel) : '0))
    else $error("Loopback kind does not follow enable and selection");

  man_speed_a: assert property (@(posedge clock) disable iff (sys_rst)
    !autoneg_on |=> link_speed == $past({ctrl[BIT_SPD_MSB], ctrl[BIT_SPD_LSB]}))
    else $error("Manual speed not applied");

  an_link_a: assert property (@(posedge clock) disable iff (sys_rst)
    autoneg_on |=> (link_speed == $past(an_speed))
                   && (link_full_duplex == $past(an_full_duplex)))
    else $error("Negotiated settings not applied");

  man_duplex_a: assert property (@(posedge clock) disable iff (sys_rst)
    !autoneg_on |=> link_full_duplex == $past(ctrl[BIT_DUPLEX]))
    else $error("Manual duplex not applied");

  mode_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_hit && (state == ST_RUN) && !mgmt_wdata[BIT_PHY_RST]
    |=> (isolate == $past(mgmt_wdata[BIT_ISOLATE]))
        && (power_down == $past(mgmt_wdata[BIT_PWR_DOWN]))
        && (coll_test == $past(mgmt_wdata[BIT_COLL_TEST])))
    else $error("Mode bits not taken from write");

  anr_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(an_restart) ##0 (!mgmt_wr) [*2] |-> ##1 !an_restart)
    else $error("Restart bit did not clear itself");

  rsvd_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
    mgmt_rvalid |-> (mgmt_rdata[5:0] == 6'h00) && (ctrl[5:0] == 6'h00))
    else $error("Reserved field not zero");

  reset_val_a: assert property (@(posedge clock)
    $past(sys_rst) |-> autoneg_on && (ctrl == CTRL_RESET_VAL) && !phy_rst_busy)
    else $error("Wrong value after reset");

  // Counts how long the restart bit has stood, for the minimum length check
  logic [15:0] anr_hi_cnt;

  always_ff @(posedge clock) begin
    if (sys_rst || !ctrl[BIT_AN_RESTART]) begin
      anr_hi_cnt <= 16'h0000;
    end else begin
      anr_hi_cnt <= anr_hi_cnt + 16'h0001;
    end
  end

  read_data_a: assert property (@(posedge clock) disable iff (sys_rst)
    mgmt_rd && (mgmt_addr == CTRL_ADDR) |=> mgmt_rvalid && (mgmt_rdata == $past(ctrl)))
    else $error("Read data or valid wrong");

  read_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    !(mgmt_rd && (mgmt_addr == CTRL_ADDR)) |=> !mgmt_rvalid && (mgmt_rdata == 16'h0000))
    else $error("Read answer without a read");

  rst_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_PHY_RST) && !rst_done |=> phy_rst_busy)
    else $error("PHY reset bit cleared early");

  rst_freeze_a: assert property (@(posedge clock) disable iff (sys_rst)
    (state == ST_PHY_RST) |=> ctrl[14:0] == $past(ctrl[14:0]))
    else $error("Control changed during PHY reset");

  rst_defaults_a: assert property (@(posedge clock) disable iff (sys_rst)
    rst_start |=> (ctrl == (CTRL_RESET_VAL | 16'h8000)) && !an_restart)
    else $error("PHY reset did not load defaults");

  rst_end_a: assert property (@(posedge clock) disable iff (sys_rst)
    rst_done && (state == ST_PHY_RST) |=> !phy_rst_busy && (state == ST_RUN))
    else $error("PHY reset did not end");

  rst_full_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(phy_rst_busy) |-> rst_hi_cnt == 16'(RST_CYC))
    else $error("PHY reset length wrong");

  loop_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_hit && (state == ST_RUN) && !mgmt_wdata[BIT_PHY_RST]
    |=> loopback_on == $past(mgmt_wdata[BIT_LOOPBACK]))
    else $error("Loopback enable not taken from write");

  an_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_hit && (state == ST_RUN) && !mgmt_wdata[BIT_PHY_RST]
    |=> autoneg_on == $past(mgmt_wdata[BIT_AUTONEG_ON]))
    else $error("Auto-negotiation enable not taken from write");

  duplex_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_hit && (state == ST_RUN) && !mgmt_wdata[BIT_PHY_RST]
    |=> ctrl[BIT_DUPLEX] == $past(mgmt_wdata[BIT_DUPLEX]))
    else $error("Duplex bit not taken from write");

  speed_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    wr_hit && (state == ST_RUN) && !mgmt_wdata[BIT_PHY_RST]
    |=> {ctrl[BIT_SPD_MSB], ctrl[BIT_SPD_LSB]}
        == $past({mgmt_wdata[BIT_SPD_MSB], mgmt_wdata[BIT_SPD_LSB]}))
    else $error("Speed field not taken from write");

  anr_set_a: assert property (@(posedge clock) disable iff (sys_rst)
    anr_start |=> an_restart)
    else $error("Restart bit not set on write");

  anr_end_a: assert property (@(posedge clock) disable iff (sys_rst)
    anr_done && !anr_start |=> !an_restart)
    else $error("Restart bit outlived its timer");

  anr_full_a: assert property (@(posedge clock) disable iff (sys_rst)
    $fell(an_restart) && !$past(rst_start) |-> anr_hi_cnt >= 16'(ANR_CYC))
    else $error("Restart bit cleared too early");

  mode_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    !wr_hit && (state == ST_RUN)
    |=> $stable(isolate) && $stable(power_down) && $stable(coll_test))
    else $error("Mode bits changed without a write");

endmodule // pbc_ctrl_reg

/* core/pbc_pkg.sv */
// Shared constants and types for the PHY basic control register block
package pbc_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 5000;
  // Time the PHY core spends in its internal reset
  localparam int PHY_RST_TIME_NS = 1000;
  localparam int PHY_RST_CYCLES = (PHY_RST_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Time the auto-negotiation restart request is held
  localparam int AN_RESTART_TIME_NS = 10;
  localparam int AN_RESTART_CYCLES =
      (AN_RESTART_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int MGMT_ADDR_W = 5;
  localparam int MGMT_DATA_W = 16;
  localparam logic [4:0] CTRL_ADDR = 5'h00;
  localparam logic [4:0] LOOP_CTRL_ADDR = 5'h13;
  localparam int LOOP_KIND_W = 2;

  // Field positions of the control register
  localparam int BIT_PHY_RST = 15;
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_SPD_LSB = 13;
  localparam int BIT_AUTONEG_ON = 12;
  localparam int BIT_PWR_DOWN = 11;
  localparam int BIT_ISOLATE = 10;
  localparam int BIT_AN_RESTART = 9;
  localparam int BIT_DUPLEX = 8;
  localparam int BIT_COLL_TEST = 7;
  localparam int BIT_SPD_MSB = 6;

  localparam logic [15:0] CTRL_RESET_VAL = 16'h1140;
  localparam logic [15:0] CTRL_RSVD_MASK = 16'h003f;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SPD_10 = 2'b00,
    SPD_100 = 2'b01,
    SPD_1000 = 2'b10,
    SPD_RSVD = 2'b11
  } pbc_speed_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_PHY_RST = 2'b10
  } pbc_state_t;

endpackage

/* core/pbc_sc_timer.sv */
// Countdown that times one self-clearing action
`timescale 1ns/1ps
module pbc_sc_timer
  import pbc_pkg::*;
#(
  parameter int CYCLES = 2
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic start,
  output logic busy,
  output logic done
);

  logic [15:0] cnt;
  logic [15:0] next_cnt;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    if (start) begin
      // A new start reloads, so it is never lost behind an ending run
      next_cnt = 16'(CYCLES);
    end else if (cnt != 16'h0000) begin
      next_cnt = cnt - 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign busy = (cnt != 16'h0000);
  assign done = (cnt == 16'h0001) && !start;

endmodule // pbc_sc_timer

/* core/pbc_link_cfg.sv */
// Resolves the active link settings and loopback kind
`timescale 1ns/1ps
module pbc_link_cfg
  import pbc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic autoneg_on,
  input wire logic [1:0] man_speed,
  input wire logic man_full_duplex,
  input wire logic [1:0] an_speed,
  input wire logic an_full_duplex,
  input wire logic loop_en,
  input wire logic [LOOP_KIND_W-1:0] loop_kind_sel,
  output pbc_speed_t link_speed,
  output logic link_full_duplex,
  output logic [LOOP_KIND_W-1:0] loop_kind
);

  pbc_speed_t next_link_speed;
  logic next_link_full_duplex;
  logic [LOOP_KIND_W-1:0] next_loop_kind;

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  always_comb begin
    if (autoneg_on) begin
      next_link_speed = pbc_speed_t'(an_speed);
      next_link_full_duplex = an_full_duplex;
    end else begin
      next_link_speed = pbc_speed_t'(man_speed);
      next_link_full_duplex = man_full_duplex;
    end
    next_loop_kind = loop_en ? loop_kind_sel : '0;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      link_speed <= SPD_1000;
      link_full_duplex <= 1'b1;
      loop_kind <= '0;
    end else begin
      link_speed <= next_link_speed;
      link_full_duplex <= next_link_full_duplex;
      loop_kind <= next_loop_kind;
    end
  end

endmodule // pbc_link_cfg

/* verif/pbc_mgmt_station.sv */
// Management station model that drives the control register strobes
`timescale 1ns/1ps
module pbc_mgmt_station
  import pbc_pkg::*;
(
  input wire logic clock,
  output logic [MGMT_ADDR_W-1:0] mgmt_addr,
  output logic mgmt_wr,
  output logic mgmt_rd,
  output logic [MGMT_DATA_W-1:0] mgmt_wdata,
  input wire logic [MGMT_DATA_W-1:0] mgmt_rdata,
  input wire logic mgmt_rvalid
);
  initial begin
    mgmt_addr = 5'h1f;
    mgmt_wr = 1'h0;
    mgmt_rd = 1'h0;
    mgmt_wdata = 16'h5a5a;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  // One-cycle write strobe; address and data go stale once taken
  task automatic write_reg(input logic [4:0] addr, input logic [15:0] data);
    @(posedge clock);
    #1;
    mgmt_addr = addr;
    mgmt_wdata = data;
    mgmt_wr = 1'h1;
    @(posedge clock);
    #1;
    mgmt_wr = 1'h0;
    mgmt_addr = ~addr;
    mgmt_wdata = ~data;
  endtask

  // Read data and valid are registered one edge after the strobe
  task automatic read_reg(input logic [4:0] addr, output logic [15:0] data,
                          output logic valid);
    @(posedge clock);
    #1;
    mgmt_addr = addr;
    mgmt_rd = 1'h1;
    @(posedge clock);
    #1;
    mgmt_rd = 1'h0;
    mgmt_addr = ~addr;
    data = mgmt_rdata;
    valid = mgmt_rvalid;
  endtask
endmodule // pbc_mgmt_station

/* verif/pbc_ctrl_reg_test.sv */
// Self-checking testbench for the PHY basic control register
`timescale 1ns/1ps
module pbc_ctrl_reg_test;
  import pbc_pkg::*;
  localparam int RST_N = 8;
  localparam int ANR_N = 2;
  logic clock;
  logic sys_rst;
  logic [4:0] mgmt_addr;
  logic mgmt_wr;
  logic mgmt_rd;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic mgmt_rvalid;
  logic [1:0] loop_kind_sel;
  logic [1:0] an_speed;
  logic an_full_duplex;
  logic phy_rst_busy;
  logic loopback_on;
  logic [1:0] loop_kind;
  logic autoneg_on;
  logic an_restart;
  logic power_down;
  logic isolate;
  logic coll_test;
  pbc_speed_t link_speed;
  logic link_full_duplex;
  logic [15:0] rd;
  logic rv;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;

  pbc_mgmt_station pbc_mgmt_station_inst (.clock(clock), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

  pbc_ctrl_reg #(.RST_CYC(RST_N), .ANR_CYC(ANR_N)) pbc_ctrl_reg_inst (.clock(clock),
    .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .loop_kind_sel(loop_kind_sel), .an_speed(an_speed), .an_full_duplex(an_full_duplex),
    .phy_rst_busy(phy_rst_busy), .loopback_on(loopback_on), .loop_kind(loop_kind),
    .autoneg_on(autoneg_on), .an_restart(an_restart), .power_down(power_down),
    .isolate(isolate), .coll_test(coll_test), .link_speed(link_speed),
    .link_full_duplex(link_full_duplex));

  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_check(input logic [15:0] exp);
    pbc_mgmt_station_inst.read_reg(CTRL_ADDR, rd, rv);
    check("rvalid", rv, 16'h1);
    check("ctrl", rd, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge clock);
    #1;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'h1;
    loop_kind_sel = 2'h3;
    an_speed = 2'h2;
    an_full_duplex = 1'h1;
    repeat (4) @(posedge clock);
    #1;
    sys_rst = 1'h0;
    check("autoneg_rst", autoneg_on, 16'h1);
    rd_check(16'h1140);
    pbc_mgmt_station_inst.write_reg(CTRL_ADDR, 16'h4dbf);
    settle();
    rd_check(16'h4d80);
    check("ctl_outs", {loopback_on, power_down, isolate, coll_test, autoneg_on}, 16'h1e);
    check("loop_kind", loop_kind, 16'h3);
    for (int s = 0; s < 4; s++) begin
      pbc_mgmt_station_inst.write_reg(CTRL_ADDR, {2'h0, s[0], 6'h0, s[1], 6'h0});
      settle();
      check("man_speed", link_speed, 16'(s));
      check("man_duplex", link_full_duplex, 16'h0);
      an_speed = 2'(3 - s);
      pbc_mgmt_station_inst.write_reg(CTRL_ADDR, {2'h0, s[0], 6'h20, s[1], 6'h0});
      settle();
      check("an_speed", link_speed, 16'(3 - s));
      check("an_duplex", link_full_duplex, 16'h1);
      check("loop_off", {loopback_on, loop_kind}, 16'h0);
    end
    pbc_mgmt_station_inst.write_reg(CTRL_ADDR, 16'h1200);
    n = 0;
    while (an_restart === 1'h1 && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("restart_len", 16'(n), 16'(ANR_N));
    rd_check(16'h1000);
    pbc_mgmt_station_inst.write_reg(CTRL_ADDR, 16'h0800);
    settle();
    pbc_mgmt_station_inst.write_reg(CTRL_ADDR, 16'h8000);
    check("rst_busy", phy_rst_busy, 16'h1);
    check("pd_cleared", power_down, 16'h0);
    rd_check(16'h9140);
    // Ignored because the PHY reset is still running
    pbc_mgmt_station_inst.write_reg(CTRL_ADDR, 16'h0800);
    n = 0;
    while (phy_rst_busy === 1'h1 && n < 50) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("rst_len", 16'(n), 16'(RST_N - 4));
    rd_check(16'h1140);
    pbc_mgmt_station_inst.write_reg(5'h01, 16'h0000);
    pbc_mgmt_station_inst.read_reg(5'h01, rd, rv);
    check("other_rvalid", rv, 16'h0);
    check("other_rdata", rd, 16'h0);
    rd_check(16'h1140);
    conclude();
  end
endmodule // pbc_ctrl_reg_test
